//--- scdc_cfg.svh
// Register offsets, field positions, reset values and counts of the drive block
`ifndef SCDC_CFG_SVH
`define SCDC_CFG_SVH
`define SCDC_OFF_CMD 8'h00
`define SCDC_OFF_INMODE 8'h04
`define SCDC_OFF_LIMMODE 8'h08
`define SCDC_OFF_ACCMODE 8'h0c
`define SCDC_OFF_MAINST 8'h10
`define SCDC_OFF_DRVST 8'h14
`define SCDC_OFF_CAUSE 8'h18
`define SCDC_OFF_ICLR 8'h1c
`define SCDC_OFF_IEN 8'h20
`define SCDC_OFF_PCNT 8'h24
`define SCDC_OFF_SV 8'h28
`define SCDC_OFF_V 8'h2c
`define SCDC_OFF_POS 8'h30
`define SCDC_OFF_SWP 8'h34
`define SCDC_OFF_SWM 8'h38
`define SCDC_OFF_SPEED 8'h3c
`define SCDC_CMD_FIX_FWD 8'h20
`define SCDC_CMD_FIX_REV 8'h21
`define SCDC_CMD_CON_FWD 8'h22
`define SCDC_CMD_CON_REV 8'h23
`define SCDC_CMD_DECEL 8'h26
`define SCDC_CMD_SUDDEN 8'h27
`define SCDC_CMD_CLRACC 8'h44
`define SCDC_BIT_AXIS 8
`define SCDC_BIT_SCURVE 2
`define SCDC_BIT_SWP_EN 0
`define SCDC_BIT_SWM_EN 1
`define SCDC_BIT_LIM_DEC 2
`define SCDC_BIT_STOP0 1
`define SCDC_BIT_STOP1 3
`define SCDC_BIT_STOP2 5
`define SCDC_BIT_CEND_EN 13
`define SCDC_BIT_CEND 5
`define SCDC_BIT_DRV 0
`define SCDC_BIT_ACC 2
`define SCDC_BIT_CONSTANT_SPEED_FLAG 3
`define SCDC_BIT_DEC 4
`define SCDC_BIT_LIMF 12
`define SCDC_BIT_LIMR 13
`define SCDC_RST_SV 16'h0064
`define SCDC_RST_V 16'h0fa0
`define SCDC_UPD_CYC 8
`define SCDC_ACC_MAX 16
`define SCDC_LIN_STEP 4
`endif

//--- scdc_drive_ctrl.sv
// Drive sequencer, stop logic and Wishbone register file of one axis
`timescale 1ns/1ps
`include "scdc_cfg.svh"
// Behaviour
// - S-curve select bit set makes fixed and continuous drives use S-curve.
// - Clear-counter command zeroes the axis S-curve acceleration counter.
// - Codes start fixed forward, fixed reverse, continuous forward and continuous reverse drive.
// - Position limit comparison only valid within a signed 31-bit range.
// - Fixed S-curve drive aims to end at initial speed, zero acceleration.
// - Drive status shows accelerating, constant and decelerating in bits 2-4.
// - Drive-active flag reads one while driving; all phases zero is runaway.
// - Constant-speed end sets its cause flag and interrupt when enabled.
// - Drive status bits 12 and 13 show forward and reverse hardware limits.
// - Decelerating-stop command brakes; sudden-stop command halts at once.
// - Limit-stop-mode bit picks decelerating or sudden stop on travel limit.
// - Two low limit-mode bits enable software limits as stop factors.
// - Input mode bits 5, 3, 1 enable external stops, which decelerate.
// - Sudden command, emergency, sudden-mode limit or alarm halt at once.
module scdc_drive_ctrl #(
	parameter int UPD_CYC = `SCDC_UPD_CYC,
	parameter int ACC_MAX = `SCDC_ACC_MAX,
	parameter int LIN_STEP = `SCDC_LIN_STEP
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic limit_fwd_n_i,
	input wire logic limit_rev_n_i,
	input wire logic [2:0] ext_stop_n_i,
	input wire logic emg_stop_n_i,
	input wire logic alarm_i,
	output logic pulse_o,
	output logic dir_o,
	output logic irq_o
);
	scdc_ramp_if rif();

	logic ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;
	logic [15:0] inmode_ff, nxt_inmode;
	logic [15:0] limmode_ff, nxt_limmode;
	logic [15:0] accmode_ff, nxt_accmode;
	logic [31:0] pcnt_ff, nxt_pcnt, swp_ff, nxt_swp, swm_ff, nxt_swm;
	logic [31:0] pos_ff, nxt_pos;
	logic [15:0] sv_ff, nxt_sv, v_ff, nxt_v;
	logic cause_ff, nxt_cause, ien_ff, nxt_ien;
	logic dir_ff, nxt_dir, pulse_ff, nxt_pulse;
	logic wr, cmd_wr, axis_sel;
	logic [7:0] code;
	logic lim_f, lim_r, lim_travel, sw_hit, ext_hit;
	logic sudden, decel, start, fixed;
	logic [31:0] main_st, drv_st, rd_val;

	// Signed compare on the low 31 bits only; wider values wrap
	function automatic logic ge31(input logic [31:0] a, input logic [31:0] b);
		return $signed(a[30:0]) >= $signed(b[30:0]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (dat & m);
	endfunction

	// Writes commit at the edge where the master sees ack
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
	assign cmd_wr = wr && wb_adr_i == `SCDC_OFF_CMD && wb_sel_i[0];
	assign code = wb_dat_i[7:0];
	assign axis_sel = wb_dat_i[`SCDC_BIT_AXIS] && wb_sel_i[1];

	assign lim_f = !limit_fwd_n_i;
	assign lim_r = !limit_rev_n_i;
	assign lim_travel = dir_ff ? lim_r : lim_f;
	assign sw_hit = rif.active && (
		(limmode_ff[`SCDC_BIT_SWP_EN] && !dir_ff && ge31(pos_ff, swp_ff)) ||
		(limmode_ff[`SCDC_BIT_SWM_EN] && dir_ff && ge31(swm_ff, pos_ff)));
	assign ext_hit = |(~ext_stop_n_i & {inmode_ff[`SCDC_BIT_STOP2],
		inmode_ff[`SCDC_BIT_STOP1], inmode_ff[`SCDC_BIT_STOP0]});

	// Emergency and alarm act even without a bus command
	assign sudden = (cmd_wr && axis_sel && code == `SCDC_CMD_SUDDEN) ||
		!emg_stop_n_i || alarm_i ||
		(lim_travel && !limmode_ff[`SCDC_BIT_LIM_DEC]);
	assign decel = (cmd_wr && axis_sel && code == `SCDC_CMD_DECEL) ||
		(lim_travel && limmode_ff[`SCDC_BIT_LIM_DEC]) ||
		sw_hit || ext_hit;

	always_comb
	begin
		start = 1'b0;
		fixed = 1'b0;
		if (cmd_wr && axis_sel && !rif.active)
		begin
			case (code)
				`SCDC_CMD_FIX_FWD, `SCDC_CMD_FIX_REV:
				begin
					start = 1'b1;
					fixed = 1'b1;
				end
				`SCDC_CMD_CON_FWD, `SCDC_CMD_CON_REV:
					start = 1'b1;
				default:
					start = 1'b0;
			endcase
		end
	end

	assign rif.ce = ce_i;
	assign rif.start = start;
	assign rif.fixed = fixed;
	assign rif.scurve = accmode_ff[`SCDC_BIT_SCURVE];
	assign rif.clr_acc = cmd_wr && axis_sel &&
		code == `SCDC_CMD_CLRACC;
	assign rif.decel_req = decel && rif.active;
	assign rif.halt = sudden && rif.active;
	assign rif.init_speed = sv_ff;
	assign rif.drive_speed = v_ff;
	assign rif.pulse_cnt = pcnt_ff;

	always_comb
	begin
		main_st = 32'h0;
		main_st[`SCDC_BIT_DRV] = rif.active;
		drv_st = 32'h0;
		drv_st[`SCDC_BIT_ACC] = rif.phase == scdc_pkg::SCDC_PH_ACC;
		drv_st[`SCDC_BIT_CONSTANT_SPEED_FLAG] = rif.phase == scdc_pkg::SCDC_PH_CONST;
		drv_st[`SCDC_BIT_DEC] = rif.phase == scdc_pkg::SCDC_PH_DEC;
		drv_st[`SCDC_BIT_LIMF] = lim_f;
		drv_st[`SCDC_BIT_LIMR] = lim_r;
		case (wb_adr_i)
			`SCDC_OFF_INMODE: rd_val = {16'h0, inmode_ff};
			`SCDC_OFF_LIMMODE: rd_val = {16'h0, limmode_ff};
			`SCDC_OFF_ACCMODE: rd_val = {16'h0, accmode_ff};
			`SCDC_OFF_MAINST: rd_val = main_st;
			`SCDC_OFF_DRVST: rd_val = drv_st;
			`SCDC_OFF_CAUSE: rd_val = 32'(cause_ff) << `SCDC_BIT_CEND;
			`SCDC_OFF_IEN: rd_val = 32'(ien_ff) << `SCDC_BIT_CEND;
			`SCDC_OFF_PCNT: rd_val = pcnt_ff;
			`SCDC_OFF_SV: rd_val = {16'h0, sv_ff};
			`SCDC_OFF_V: rd_val = {16'h0, v_ff};
			`SCDC_OFF_POS: rd_val = pos_ff;
			`SCDC_OFF_SWP: rd_val = swp_ff;
			`SCDC_OFF_SWM: rd_val = swm_ff;
			`SCDC_OFF_SPEED: rd_val = {16'h0, rif.speed};
			default: rd_val = 32'h0;
		endcase
	end

	always_comb
	begin
		nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
		nxt_rdat = nxt_ack ? rd_val : rdat_ff;
		nxt_inmode = inmode_ff;
		nxt_limmode = limmode_ff;
		nxt_accmode = accmode_ff;
		nxt_pcnt = pcnt_ff;
		nxt_sv = sv_ff;
		nxt_v = v_ff;
		nxt_swp = swp_ff;
		nxt_swm = swm_ff;
		nxt_ien = ien_ff;
		nxt_cause = cause_ff;
		nxt_dir = dir_ff;
		nxt_pos = pos_ff;
		nxt_pulse = rif.step;
		if (wr)
		begin
			case (wb_adr_i)
				`SCDC_OFF_INMODE:
					nxt_inmode = 16'(merge({16'h0, inmode_ff}, wb_dat_i,
						wb_sel_i));
				`SCDC_OFF_LIMMODE:
					nxt_limmode = 16'(merge({16'h0, limmode_ff}, wb_dat_i,
						wb_sel_i));
				`SCDC_OFF_ACCMODE:
					nxt_accmode = 16'(merge({16'h0, accmode_ff}, wb_dat_i,
						wb_sel_i));
				`SCDC_OFF_PCNT: nxt_pcnt = merge(pcnt_ff, wb_dat_i, wb_sel_i);
				`SCDC_OFF_SV:
					nxt_sv = 16'(merge({16'h0, sv_ff}, wb_dat_i,
						wb_sel_i));
				`SCDC_OFF_V:
					nxt_v = 16'(merge({16'h0, v_ff}, wb_dat_i,
						wb_sel_i));
				`SCDC_OFF_SWP: nxt_swp = merge(swp_ff, wb_dat_i, wb_sel_i);
				`SCDC_OFF_SWM: nxt_swm = merge(swm_ff, wb_dat_i, wb_sel_i);
				`SCDC_OFF_POS: nxt_pos = merge(pos_ff, wb_dat_i, wb_sel_i);
				`SCDC_OFF_IEN:
					if (wb_sel_i[0])
						nxt_ien = wb_dat_i[`SCDC_BIT_CEND];
				`SCDC_OFF_ICLR:
					if (wb_sel_i[0] && wb_dat_i[`SCDC_BIT_CEND])
						nxt_cause = 1'b0;
				default:
					nxt_ien = ien_ff;
			endcase
		end
		if (start)
			nxt_dir = code == `SCDC_CMD_FIX_REV || code == `SCDC_CMD_CON_REV;
		if (rif.step)
			nxt_pos = dir_ff ? pos_ff - 32'h1 : pos_ff + 32'h1;
		// A new event wins over a clear in the same cycle
		if (rif.cend && inmode_ff[`SCDC_BIT_CEND_EN])
			nxt_cause = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
			inmode_ff <= 16'h0;
			limmode_ff <= 16'h0;
			accmode_ff <= 16'h0;
			pcnt_ff <= 32'h0;
			sv_ff <= `SCDC_RST_SV;
			v_ff <= `SCDC_RST_V;
			swp_ff <= 32'h0;
			swm_ff <= 32'h0;
			pos_ff <= 32'h0;
			ien_ff <= 1'b0;
			cause_ff <= 1'b0;
			dir_ff <= 1'b0;
			pulse_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
			inmode_ff <= nxt_inmode;
			limmode_ff <= nxt_limmode;
			accmode_ff <= nxt_accmode;
			pcnt_ff <= nxt_pcnt;
			sv_ff <= nxt_sv;
			v_ff <= nxt_v;
			swp_ff <= nxt_swp;
			swm_ff <= nxt_swm;
			pos_ff <= nxt_pos;
			ien_ff <= nxt_ien;
			cause_ff <= nxt_cause;
			dir_ff <= nxt_dir;
			pulse_ff <= nxt_pulse;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign pulse_o = pulse_ff;
	assign dir_o = dir_ff;
	assign irq_o = cause_ff && ien_ff;

	scdc_ramp #(
		.UPD_CYC(UPD_CYC),
		.ACC_MAX(ACC_MAX),
		.LIN_STEP(LIN_STEP)
	) u_ramp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rif(rif.ramp)
	);

	a_sudden_halts: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && sudden && rif.active |=> !rif.active ##1 !pulse_o)
		else $error("sudden stop left the drive running");
	a_decel_cmd_brakes: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && decel && !sudden && rif.active |=>
		rif.phase == scdc_pkg::SCDC_PH_DEC || !rif.active)
		else $error("decelerating stop did not brake");
	a_cend_sets_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		rif.cend && inmode_ff[`SCDC_BIT_CEND_EN] |=> cause_ff)
		else $error("constant end cause flag not set");
	a_clear_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && rif.clr_acc && !rif.active |=> !rif.active)
		else $error("clear counter started a drive");
	a_limit_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(wb_ack_o) && !wb_we_i && wb_adr_i == `SCDC_OFF_DRVST |->
		wb_dat_o[`SCDC_BIT_LIMR:`SCDC_BIT_LIMF] ==
		$past({!limit_rev_n_i, !limit_fwd_n_i}))
		else $error("limit status bits wrong");
	a_active_phase: assert property (@(posedge clk_i) disable iff (rst_i)
		main_st[`SCDC_BIT_DRV] |-> |drv_st[4:2])
		else $error("driving with no phase flag");
	a_scurve_counter: assert property (@(posedge clk_i) disable iff (rst_i)
		!accmode_ff[`SCDC_BIT_SCURVE] && !rif.clr_acc |=>
		$stable(rif.acc))
		else $error("acceleration counter moved in linear mode");
endmodule

//--- scdc_motor_model.sv
// Motor driver model that counts drive pulses
`timescale 1ns/1ps
module scdc_motor_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic step_i,
	input wire logic dir_i,
	output logic [31:0] pos_o,
	output logic [31:0] cnt_o,
	output logic dir_err_o
);
	logic dir_q;
	// Direction must settle a cycle before a step, or the model latches dir_err_o
	always_ff @(posedge clk_i)
	begin
		dir_q <= dir_i;
		if (rst_i)
		begin
			pos_o <= 32'h0;
			cnt_o <= 32'h0;
			dir_err_o <= 1'b0;
		end
		else if (step_i)
		begin
			cnt_o <= cnt_o + 32'h1;
			pos_o <= dir_i ? pos_o - 32'h1 : pos_o + 32'h1;
			if (dir_i != dir_q)
				dir_err_o <= 1'b1;
		end
	end
endmodule

//--- scdc_pkg.sv
// Shared types of the drive block
package scdc_pkg;
	typedef enum logic [1:0] {
		SCDC_PH_IDLE = 2'b00,
		SCDC_PH_ACC = 2'b01,
		SCDC_PH_CONST = 2'b10,
		SCDC_PH_DEC = 2'b11
	} scdc_phase_t;
endpackage

//--- scdc_ramp.sv
// Speed ramp and pulse-rate generator
`timescale 1ns/1ps
`include "scdc_cfg.svh"
module scdc_ramp #(
	parameter int UPD_CYC = `SCDC_UPD_CYC,
	parameter int ACC_MAX = `SCDC_ACC_MAX,
	parameter int LIN_STEP = `SCDC_LIN_STEP
)(
	input wire logic clk_i,
	input wire logic rst_i,
	scdc_ramp_if.ramp rif
);
	scdc_pkg::scdc_phase_t st_ff, nxt_st;
	logic [15:0] speed_ff, nxt_speed, acc_ff, nxt_acc, accum_ff, nxt_accum;
	logic [31:0] left_ff, nxt_left, used_ff, nxt_used;
	logic [7:0] tick_ff, nxt_tick;
	logic fixed_ff, nxt_fixed, decel_ff, nxt_decel, tail_ff, nxt_tail;
	logic [16:0] sum, up;
	logic [15:0] d, dd;
	logic step, upd, cend, dreq, near_end;

	function automatic logic [15:0] clamp(input logic [16:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v > {1'b0, hi})
			return hi;
		if (v < {1'b0, lo})
			return lo;
		return v[15:0];
	endfunction

	always_comb
	begin
		nxt_st = st_ff;
		nxt_speed = speed_ff;
		nxt_acc = acc_ff;
		nxt_accum = accum_ff;
		nxt_left = left_ff;
		nxt_used = used_ff;
		nxt_tick = tick_ff;
		nxt_fixed = fixed_ff;
		nxt_decel = decel_ff;
		nxt_tail = tail_ff;
		cend = 1'b0;
		sum = {1'b0, accum_ff} + {1'b0, speed_ff};
		step = (st_ff != scdc_pkg::SCDC_PH_IDLE) && sum[16];
		upd = tick_ff == 8'(UPD_CYC - 1);
		d = rif.scurve ? acc_ff : 16'(LIN_STEP);
		// Braking step has a floor, so a spent S-curve counter cannot stall it
		dd = (d > 16'(LIN_STEP)) ? d : 16'(LIN_STEP);
		up = {1'b0, speed_ff} + {1'b0, d};
		dreq = decel_ff || rif.decel_req;
		// Braking begins once the pulses left are at most one more than those spent speeding up
		near_end = fixed_ff && (left_ff <= used_ff + 32'h1);
		if (st_ff != scdc_pkg::SCDC_PH_IDLE)
		begin
			nxt_accum = sum[15:0];
			nxt_tick = upd ? 8'h0 : tick_ff + 8'h1;
			if (step)
				nxt_left = left_ff - 32'h1;
			if (rif.decel_req)
				nxt_decel = 1'b1;
		end
		case (st_ff)
			scdc_pkg::SCDC_PH_IDLE:
				if (rif.start && !(rif.fixed && rif.pulse_cnt == 32'h0))
				begin
					nxt_st = scdc_pkg::SCDC_PH_ACC;
					nxt_speed = rif.init_speed;
					nxt_left = rif.pulse_cnt;
					nxt_used = 32'h0;
					nxt_fixed = rif.fixed;
					nxt_decel = 1'b0;
					nxt_tail = 1'b0;
					nxt_accum = 16'h0;
					nxt_tick = 8'h0;
				end
			scdc_pkg::SCDC_PH_ACC:
			begin
				if (step)
					nxt_used = used_ff + 32'h1;
				if (upd)
				begin
					if (rif.scurve && acc_ff < 16'(ACC_MAX))
						nxt_acc = acc_ff + 16'h1;
					nxt_speed = clamp(up, rif.init_speed, rif.drive_speed);
					if (up >= {1'b0, rif.drive_speed})
						nxt_st = scdc_pkg::SCDC_PH_CONST;
				end
				if (near_end || dreq)
					nxt_st = scdc_pkg::SCDC_PH_DEC;
			end
			scdc_pkg::SCDC_PH_CONST:
				if (!tail_ff && (near_end || dreq))
				begin
					nxt_st = scdc_pkg::SCDC_PH_DEC;
					cend = 1'b1;
				end
			scdc_pkg::SCDC_PH_DEC:
				if (upd)
				begin
					if (rif.scurve && acc_ff != 16'h0)
						nxt_acc = acc_ff - 16'h1;
					nxt_speed = clamp((dd > speed_ff) ? 17'h0 :
						{1'b0, speed_ff - dd}, rif.init_speed, rif.drive_speed);
					if (nxt_speed <= rif.init_speed)
					begin
						// Short tail at the initial speed uses up the last pulses
						if (dreq || !fixed_ff)
							nxt_st = scdc_pkg::SCDC_PH_IDLE;
						else
						begin
							nxt_st = scdc_pkg::SCDC_PH_CONST;
							nxt_tail = 1'b1;
						end
					end
				end
			default:
				nxt_st = scdc_pkg::SCDC_PH_IDLE;
		endcase
		if (fixed_ff && step && left_ff == 32'h1)
		begin
			nxt_st = scdc_pkg::SCDC_PH_IDLE;
			if (st_ff == scdc_pkg::SCDC_PH_CONST)
				cend = 1'b1;
		end
		if (rif.halt)
			nxt_st = scdc_pkg::SCDC_PH_IDLE;
		if (rif.clr_acc)
			nxt_acc = 16'h0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_ff <= scdc_pkg::SCDC_PH_IDLE;
			speed_ff <= 16'h0;
			acc_ff <= 16'h0;
			accum_ff <= 16'h0;
			left_ff <= 32'h0;
			used_ff <= 32'h0;
			tick_ff <= 8'h0;
			fixed_ff <= 1'b0;
			decel_ff <= 1'b0;
			tail_ff <= 1'b0;
		end
		else if (rif.ce)
		begin
			st_ff <= nxt_st;
			speed_ff <= nxt_speed;
			acc_ff <= nxt_acc;
			accum_ff <= nxt_accum;
			left_ff <= nxt_left;
			used_ff <= nxt_used;
			tick_ff <= nxt_tick;
			fixed_ff <= nxt_fixed;
			decel_ff <= nxt_decel;
			tail_ff <= nxt_tail;
		end
	end

	assign rif.step = step && rif.ce;
	assign rif.active = st_ff != scdc_pkg::SCDC_PH_IDLE;
	assign rif.cend = cend && rif.ce;
	assign rif.speed = speed_ff;
	assign rif.acc = acc_ff;
	assign rif.phase = st_ff;

	sequence s_go;
		rif.ce && rif.start && !rif.halt && !rif.active && rif.pulse_cnt != 0;
	endsequence
	a_start_enters_accel: assert property (@(posedge clk_i) disable iff (rst_i)
		s_go |=> st_ff == scdc_pkg::SCDC_PH_ACC)
		else $error("drive start did not enter acceleration");
	a_halt_ends_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		rif.ce && rif.halt |=> !rif.active)
		else $error("halt did not stop pulse output");
	a_clear_acc_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		rif.ce && rif.clr_acc |=> acc_ff == 16'h0)
		else $error("acceleration counter not cleared");
	a_cend_from_const: assert property (@(posedge clk_i) disable iff (rst_i)
		rif.cend |-> st_ff == scdc_pkg::SCDC_PH_CONST)
		else $error("constant end raised outside constant phase");
endmodule

//--- scdc_ramp_if.sv
// Link between the drive sequencer and the speed ramp
`timescale 1ns/1ps
interface scdc_ramp_if;
	logic ce;
	logic start;
	logic fixed;
	logic scurve;
	logic clr_acc;
	logic decel_req;
	logic halt;
	logic [15:0] init_speed;
	logic [15:0] drive_speed;
	logic [31:0] pulse_cnt;
	logic step;
	logic active;
	logic cend;
	logic [15:0] speed;
	logic [15:0] acc;
	scdc_pkg::scdc_phase_t phase;
	modport ctrl (output ce, start, fixed, scurve, clr_acc, decel_req, halt,
		init_speed, drive_speed, pulse_cnt,
		input step, active, cend, speed, acc, phase);
	modport ramp (input ce, start, fixed, scurve, clr_acc, decel_req, halt,
		init_speed, drive_speed, pulse_cnt,
		output step, active, cend, speed, acc, phase);
endinterface

//--- tb_scurve_drive_control.sv
// Self-checking bench of the drive sequencer
`timescale 1ns/1ps
`include "scdc_cfg.svh"
module tb_scurve_drive_control;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc = 0, stb = 0, we = 0, ack, pulse, dir, irq;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, dat_o, q, mpos, mcnt, ep, c0, seed;
	logic lf_n = 1, lr_n = 1, emg_n = 1, alarm = 0, derr, seen;
	logic [2:0] es_n = 3'h7;
	logic [15:0] sv, mid;
	int fail_count = 0, tests_run = 0, k, d, p;
	always #2.5 clk_i = ~clk_i;
	scdc_drive_ctrl #(.UPD_CYC(2)) scdc_drive_ctrl_i (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .limit_fwd_n_i(lf_n),
		.limit_rev_n_i(lr_n), .ext_stop_n_i(es_n), .emg_stop_n_i(emg_n),
		.alarm_i(alarm), .pulse_o(pulse), .dir_o(dir), .irq_o(irq));
	scdc_motor_model scdc_motor_model_i (.clk_i(clk_i), .rst_i(rst_i),
		.step_i(pulse), .dir_i(dir), .pos_o(mpos), .cnt_o(mcnt),
		.dir_err_o(derr));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	// Classic cycle; the slave must answer on the second clock edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		sel <= 4'hf;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1);
		q = dat_o;
		chk("ack", n, 32'd2);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'b1, a, v);
	endtask
	task rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task start(input logic [7:0] c);
		wr(`SCDC_OFF_CMD, 32'h144);
		wr(`SCDC_OFF_CMD, {23'h0, 1'b1, c});
	endtask
	task idle();
		logic [31:0] s;
		int n;
		logic hit;
		n = 0;
		hit = 1'b0;
		seen = 1'b0;
		q = 32'h1;
		while (q[0] === 1'b1 && n < 3000)
		begin
			rd(`SCDC_OFF_DRVST);
			s = q;
			rd(`SCDC_OFF_MAINST);
			if (q[0] === 1'b1)
				chk("phase", |s[4:2], 1'b1);
			// Runaway with a limit active gets exactly one sudden stop
			if (q[0] === 1'b1 && s[4:2] == 3'h0 && |s[13:12] && !hit)
			begin
				wr(`SCDC_OFF_CMD, 32'h127);
				hit = 1'b1;
			end
			if (s[4] === 1'b1)
				seen = 1'b1;
			n++;
		end
		chk("idle", q[0], 1'b0);
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clk_i);
		fail_count++;
		finish_test();
	end
	initial
	begin
		seed = 32'd9540;
		ep = 32'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`SCDC_OFF_SV);
		chk("sv rst", q, 32'h64);
		rd(`SCDC_OFF_V);
		chk("v rst", q, 32'hfa0);
		wr(8'hfc, 32'hffff_ffff);
		rd(8'hfc);
		chk("unmapped", q, 32'h0);
		lr_n <= 1'b0;
		rd(`SCDC_OFF_DRVST);
		chk("lim rev", q[13:12], 2'b10);
		lr_n <= 1'b1;
		$display("test reset done");
		sv = 16'h0300 + 16'(rnd() & 32'hff);
		mid = (16'h1000 - sv) / 2 + sv;
		wr(`SCDC_OFF_SV, {16'h0, sv});
		wr(`SCDC_OFF_V, 32'h1000);
		wr(`SCDC_OFF_ACCMODE, 32'h4);
		wr(`SCDC_OFF_IEN, 32'h20);
		wr(`SCDC_OFF_INMODE, 32'h202a);
		// Sw limits stay off, so any fixed target is allowed
		for (d = 0; d < 2; d++)
		begin
			p = 16 + (rnd() & 31);
			c0 = mcnt;
			wr(`SCDC_OFF_PCNT, p);
			start(d ? `SCDC_CMD_FIX_REV : `SCDC_CMD_FIX_FWD);
			idle();
			ep = d ? ep - p : ep + p;
			chk("pulses", mcnt - c0, p);
			chk("dir", dir, d[0]);
			rd(`SCDC_OFF_POS);
			chk("pos", q, ep);
			chk("motor pos", mpos, ep);
		end
		wr(`SCDC_OFF_PCNT, 32'h0);
		start(`SCDC_CMD_FIX_FWD);
		c0 = mcnt;
		wr(`SCDC_OFF_CMD, 32'h144);
		wr(`SCDC_OFF_CMD, 32'h020);
		repeat (200) @(posedge clk_i);
		rd(`SCDC_OFF_MAINST);
		chk("no start", q[0], 1'b0);
		chk("no pulse", mcnt, c0);
		wr(`SCDC_OFF_ICLR, 32'h20);
		$display("test fixed done");
		// Stop sources: 0-3 halt at once, 4-8 brake first
		for (k = 0; k < 9; k++)
		begin
			wr(`SCDC_OFF_LIMMODE, k == 4 ? 32'h4 : 32'h0);
			start(`SCDC_CMD_CON_FWD);
			repeat (2000) @(posedge clk_i);
			rd(`SCDC_OFF_DRVST);
			chk("const", q[3], 1'b1);
			rd(`SCDC_OFF_SPEED);
			chk("mid speed", q[15:0] >= mid, 1'b1);
			case (k)
				0: wr(`SCDC_OFF_CMD, 32'h127);
				1: emg_n <= 1'b0;
				2: alarm <= 1'b1;
				3, 4: lf_n <= 1'b0;
				8: wr(`SCDC_OFF_CMD, 32'h126);
				default: es_n[k-5] <= 1'b0;
			endcase
			if (k < 4)
			begin
				repeat (3) @(posedge clk_i);
				rd(`SCDC_OFF_MAINST);
				chk("halt", q[0], 1'b0);
				c0 = mcnt;
				repeat (100) @(posedge clk_i);
				chk("no tail", mcnt, c0);
			end
			else
			begin
				idle();
				chk("braked", seen, 1'b1);
				rd(`SCDC_OFF_CAUSE);
				chk("cause", q[5], 1'b1);
				@(negedge clk_i);
				chk("irq", irq, 1'b1);
			end
			if (k == 3 || k == 4)
			begin
				rd(`SCDC_OFF_DRVST);
				chk("lim fwd", q[12], 1'b1);
			end
			emg_n <= 1'b1;
			alarm <= 1'b0;
			lf_n <= 1'b1;
			es_n <= 3'h7;
			if (k == 8)
			begin
				wr(`SCDC_OFF_IEN, 32'h0);
				@(negedge clk_i);
				chk("irq mask", irq, 1'b0);
				wr(`SCDC_OFF_IEN, 32'h20);
			end
			wr(`SCDC_OFF_ICLR, 32'h20);
			@(negedge clk_i);
			chk("irq clr", irq, 1'b0);
			$display("test stop %0d done", k);
		end
		wr(`SCDC_OFF_POS, 32'h3fff_fff0);
		wr(`SCDC_OFF_SWP, 32'h3fff_fff8);
		wr(`SCDC_OFF_LIMMODE, 32'h1);
		start(`SCDC_CMD_CON_FWD);
		idle();
		rd(`SCDC_OFF_POS);
		chk("sw lim", $signed(q) >= $signed(32'h3fff_fff8), 1'b1);
		wr(`SCDC_OFF_ACCMODE, 32'h0);
		wr(`SCDC_OFF_POS, 32'h0);
		wr(`SCDC_OFF_SWM, 32'hffff_fff8);
		wr(`SCDC_OFF_LIMMODE, 32'h2);
		start(`SCDC_CMD_CON_REV);
		idle();
		chk("rev dir", dir, 1'b1);
		rd(`SCDC_OFF_POS);
		chk("sw lim rev", $signed(q) <= -8, 1'b1);
		chk("dir ok", derr, 1'b0);
		$display("test sw limit done");
		finish_test();
	end
endmodule
